/* File: verilog/sio_irq.sv */
// Receive and transmit interrupt-pending logic for one serial channel.
// Assumes receiver, transmitter and DMA handshake run on CORE_CLK.
//
// Function
// - Two-bit field selects receive interrupt mode
// - First mode: first character sets pending
// - Read clears; rearm by command or mode entry
// - Overrun, framing, end of frame are special
// - Parity error special when enabled
// - Special pends after read, locks until reset
// - Character and special share pending, in-service
// - Status FIFO: no lock, overrun stops DMA
// - All mode: every character pends until removed
// - All mode: special never locks FIFO
// - Special-only: pend after special character read
// - Special-only: lock blocks DMA until reset
// - Vector prefers character; character alone silent
// - Transmit pends on buffer full to empty
// - Transmit enable gates transmit requests
// - Pending bits update with master enable off
// - Sync modes: pend when CRC done
// - Underflow sends CRC, flags underrun, empty low
// - Buffer-empty set after every transmit pend
// - Write or command clears transmit pending
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/10ps

module sio_irq #(
  parameter int RX_DEPTH = sio_irq_pkg::RX_DEPTH_DEF
) (
  input  wire logic                              CORE_CLK,
  input  wire logic                              RST_B,
  input  wire logic [sio_irq_pkg::ADDR_W-1:0]    REG_ADDR,
  input  wire logic [sio_irq_pkg::DATA_W-1:0]    REG_WDATA,
  input  wire logic                              REG_WR,
  input  wire logic                              REG_RD,
  output logic      [sio_irq_pkg::DATA_W-1:0]    REG_RDATA,
  input  wire logic                              RX_CHAR_VALID,
  input  wire logic [7:0]                        RX_CHAR_DATA,
  input  wire logic                              RX_PARITY_ERR,
  input  wire logic                              RX_FRAMING_ERR,
  input  wire logic                              RX_END_OF_FRAME,
  output logic                                   DMA_RX_REQ,
  input  wire logic                              DMA_RX_ACK,
  output logic      [7:0]                        DMA_RX_DATA,
  input  wire logic                              TX_SYNC_MODE,
  input  wire logic                              TX_LOAD,
  input  wire logic                              TX_CRC_START,
  input  wire logic                              TX_CRC_DONE,
  output logic      [7:0]                        TX_DATA,
  output logic                                   TX_FULL,
  output logic                                   INT_REQ_B
);
  import sio_irq_pkg::*;

  localparam int CNT_W = $clog2(RX_DEPTH + 1);

  // ************************************************************
  // Elaboration checks
  // ************************************************************
  if (RX_DEPTH < 1 || RX_DEPTH > 16) begin : g_depth_chk
    $error("RX_DEPTH must lie in 1..16");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    logic [7:0]                          icr;
    logic [7:0]                          mcr;
    logic [1:0]                          prev_mode;
    logic [7:0]                          txbuf;
    logic                                txfull;
    logic                                txempty;
    logic                                underrun;
    logic                                tx_ip;
    logic                                armed;
    logic                                sp_pend;
    logic                                lock;
    logic                                dma_dis;
    logic                                ius_rx;
    logic                                ius_tx;
    logic [RX_DEPTH-1:0][ENT_W-1:0]      fifo;
    logic [CNT_W-1:0]                    cnt;
    logic [ENT_W-1:0]                    held;
    logic [7:0]                          rdata;
    logic                                irq_b;
    logic                                dma_req;
    logic [7:0]                          dma_data;
  } state_s;

  state_s               s_r;
  state_s               s_nxt;
  logic [1:0]           mode;
  logic                 avail;
  logic [ENT_W-1:0]     top;
  logic                 top_sp;
  logic                 pop;
  logic                 wr_cmd;
  logic [2:0]           cmd;
  logic                 rx_ip;
  logic                 tx_req;
  logic                 rx_req;
  logic [1:0]           vec;
  logic [CNT_W-1:0]     cnt_tmp;
  logic [ENT_W-1:0]     new_ent;
  logic [ENT_W-1:0]     spec_view;

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    s_nxt   = s_r;
    s_nxt.rdata = 8'h00;
    mode    = s_r.icr[ICR_MODE_LO +: 2];
    avail   = (s_r.cnt != '0) && !s_r.lock;
    top     = s_r.fifo[0];
    top_sp  = top[ENT_OVERRUN] | top[ENT_FRAMING] | top[ENT_EOF]
            | (top[ENT_PARITY] & s_r.icr[ICR_PAR_SPEC]);
    pop     = avail && ((REG_RD && REG_ADDR == RX_DATA_REG)
                        || (DMA_RX_ACK && s_r.dma_req));
    wr_cmd  = REG_WR && REG_ADDR == COMMAND_REG;
    cmd     = REG_WDATA[CMD_LO +: 3];
    cnt_tmp = s_r.cnt;
    new_ent = {RX_END_OF_FRAME, RX_FRAMING_ERR, 1'b0, RX_PARITY_ERR, RX_CHAR_DATA};

    // Receive pending per mode
    unique case (mode)
      RXM_OFF:     rx_ip = 1'b0;
      RXM_FIRST:   rx_ip = (s_r.armed && avail) || s_r.sp_pend;
      RXM_ALL:     rx_ip = avail;
      RXM_SPECIAL: rx_ip = s_r.sp_pend;
    endcase

    // Vector status: character available outranks special
    if (avail && mode != RXM_OFF) begin
      vec = VEC_RX_CHAR;
    end else if (s_r.sp_pend) begin
      vec = VEC_RX_SPECIAL;
    end else if (s_r.tx_ip) begin
      vec = VEC_TX_EMPTY;
    end else begin
      vec = VEC_NONE;
    end
    spec_view = s_r.lock ? s_r.held : top;

    // Register writes
    if (REG_WR) begin
      unique case (REG_ADDR)
        INT_CONTROL_REG: s_nxt.icr = REG_WDATA;
        MASTER_CTRL_REG: s_nxt.mcr = REG_WDATA;
        TX_BUFFER_REG: begin
          s_nxt.txbuf   = REG_WDATA;
          s_nxt.txfull  = 1'b1;
          s_nxt.txempty = 1'b0;
          s_nxt.tx_ip   = 1'b0;
        end
        default: ;
      endcase
    end

    // Commands: clears first so that same-cycle sets win
    if (wr_cmd) begin
      unique case (cmd)
        CMD_EN_NEXT_CHAR: s_nxt.armed = 1'b1;
        CMD_RST_TX_PEND:  s_nxt.tx_ip = 1'b0;
        CMD_ERROR_RESET: begin
          s_nxt.sp_pend = 1'b0;
          s_nxt.lock    = 1'b0;
          s_nxt.dma_dis = 1'b0;
        end
        CMD_RST_HIGH_IUS: begin
          if (s_r.ius_rx) begin
            s_nxt.ius_rx = 1'b0;
          end else begin
            s_nxt.ius_tx = 1'b0;
          end
        end
        CMD_RST_UNDERRUN: s_nxt.underrun = 1'b0;
        default: ;
      endcase
    end

    // Arm on entry into first-character mode
    s_nxt.prev_mode = mode;
    if (mode == RXM_FIRST && s_r.prev_mode != RXM_FIRST) begin
      s_nxt.armed = 1'b1;
    end

    // Register reads
    if (REG_RD) begin
      unique case (REG_ADDR)
        INT_CONTROL_REG:  s_nxt.rdata = s_r.icr;
        MASTER_CTRL_REG:  s_nxt.rdata = s_r.mcr;
        BASIC_STATUS_REG: begin
          s_nxt.rdata[ST_RX_AVAIL] = avail;
          s_nxt.rdata[ST_TX_EMPTY] = s_r.txempty;
          s_nxt.rdata[ST_UNDERRUN] = s_r.underrun;
        end
        SPECIAL_STAT_REG: s_nxt.rdata = {spec_view[ENT_W-1:ENT_PARITY], 4'h0};
        PENDING_REG: begin
          s_nxt.rdata[PND_TX] = s_r.tx_ip;
          s_nxt.rdata[PND_RX] = rx_ip;
        end
        VECTOR_REG: begin
          s_nxt.rdata = {6'h00, vec};
          if (rx_ip && !s_r.ius_rx) begin
            s_nxt.ius_rx = 1'b1;
          end else if (s_r.tx_ip && s_r.icr[ICR_TX_IE] && !s_r.ius_tx) begin
            s_nxt.ius_tx = 1'b1;
          end
        end
        RX_DATA_REG: s_nxt.rdata = avail ? top[7:0] : s_r.held[7:0];
        default: s_nxt.rdata = 8'h00;
      endcase
    end

    // Character removal
    if (pop) begin
      s_nxt.held = top;
      for (int i = 0; i < RX_DEPTH - 1; i++) begin
        s_nxt.fifo[i] = s_r.fifo[i+1];
      end
      cnt_tmp = CNT_W'(s_r.cnt - 1'b1);
      if (mode == RXM_FIRST) begin
        s_nxt.armed = 1'b0;
      end
      if (top_sp && (mode == RXM_FIRST || mode == RXM_SPECIAL)) begin
        s_nxt.sp_pend = 1'b1;
        s_nxt.lock    = !s_r.mcr[MCR_FS_FIFO_EN];
      end
      if (top[ENT_OVERRUN] && s_r.mcr[MCR_FS_FIFO_EN]) begin
        s_nxt.dma_dis = 1'b1;
        s_nxt.sp_pend = s_nxt.sp_pend || mode != RXM_OFF;
      end
    end

    // Character arrival; full FIFO overwrites its last entry
    if (RX_CHAR_VALID) begin
      if (cnt_tmp < CNT_W'(RX_DEPTH)) begin
        s_nxt.fifo[cnt_tmp] = new_ent;
        cnt_tmp = CNT_W'(cnt_tmp + 1'b1);
      end else begin
        new_ent[ENT_OVERRUN] = 1'b1;
        s_nxt.fifo[RX_DEPTH-1] = new_ent;
      end
    end
    s_nxt.cnt = cnt_tmp;

    // Transmit buffer moved to shift register
    if (TX_LOAD && s_r.txfull) begin
      s_nxt.txfull  = 1'b0;
      s_nxt.txempty = 1'b1;
      if (s_r.icr[ICR_TX_IE]) begin
        s_nxt.tx_ip = 1'b1;
      end
    end
    if (TX_SYNC_MODE && TX_CRC_START && !s_r.txfull) begin
      s_nxt.txempty  = 1'b0;
      s_nxt.underrun = 1'b1;
    end
    if (TX_SYNC_MODE && TX_CRC_DONE) begin
      s_nxt.txempty = 1'b1;
      if (s_r.icr[ICR_TX_IE]) begin
        s_nxt.tx_ip = 1'b1;
      end
    end

    // Interrupt request and DMA request
    rx_req = rx_ip && !s_r.ius_rx;
    tx_req = s_r.tx_ip && s_r.icr[ICR_TX_IE] && !s_r.ius_tx && !s_r.ius_rx;
    s_nxt.irq_b = !(s_r.mcr[MCR_MIE] && (rx_req || tx_req));
    s_nxt.dma_req = (s_nxt.cnt != '0) && !s_nxt.lock && !s_nxt.dma_dis
                  && s_nxt.icr[ICR_DMA_EN];
    s_nxt.dma_data = s_nxt.fifo[0][7:0];
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      s_r         <= '0;
      s_r.icr     <= ICR_RESET;
      s_r.mcr     <= MCR_RESET;
      s_r.txempty <= 1'b1;
      s_r.irq_b   <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA   = s_r.rdata;
  assign DMA_RX_REQ  = s_r.dma_req;
  assign DMA_RX_DATA = s_r.dma_data;
  assign TX_DATA     = s_r.txbuf;
  assign TX_FULL     = s_r.txfull;
  assign INT_REQ_B   = s_r.irq_b;

endmodule : sio_irq

/* File: common/sio_irq_pkg.sv */
// Constants for the serial channel receive/transmit interrupt logic.
// Assumes an 8-bit register port with a 4-bit register address.
package sio_irq_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam int         ADDR_W           = 4;
  localparam int         DATA_W           = 8;
  localparam logic [3:0] COMMAND_REG      = 4'h0;
  localparam logic [3:0] INT_CONTROL_REG  = 4'h1;
  localparam logic [3:0] TX_BUFFER_REG    = 4'h2;
  localparam logic [3:0] MASTER_CTRL_REG  = 4'h3;
  localparam logic [3:0] BASIC_STATUS_REG = 4'h4;
  localparam logic [3:0] SPECIAL_STAT_REG = 4'h5;
  localparam logic [3:0] VECTOR_REG       = 4'h6;
  localparam logic [3:0] PENDING_REG      = 4'h7;
  localparam logic [3:0] RX_DATA_REG      = 4'h8;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int ICR_TX_IE      = 1;
  localparam int ICR_PAR_SPEC   = 2;
  localparam int ICR_MODE_LO    = 3;
  localparam int ICR_DMA_EN     = 7;
  localparam int MCR_MIE        = 3;
  localparam int MCR_FS_FIFO_EN = 2;
  localparam int CMD_LO         = 3;
  localparam int ST_RX_AVAIL    = 0;
  localparam int ST_TX_EMPTY    = 2;
  localparam int ST_UNDERRUN    = 6;
  localparam int PND_TX         = 0;
  localparam int PND_RX         = 1;
  localparam int ENT_PARITY     = 8;
  localparam int ENT_OVERRUN    = 9;
  localparam int ENT_FRAMING    = 10;
  localparam int ENT_EOF        = 11;
  localparam int ENT_W          = 12;

  // ************************************************************
  // Receive modes, commands, vector status
  // ************************************************************
  localparam logic [1:0] RXM_OFF     = 2'h0;
  localparam logic [1:0] RXM_FIRST   = 2'h1;
  localparam logic [1:0] RXM_ALL     = 2'h2;
  localparam logic [1:0] RXM_SPECIAL = 2'h3;

  localparam logic [2:0] CMD_EN_NEXT_CHAR = 3'h1;
  localparam logic [2:0] CMD_RST_TX_PEND  = 3'h2;
  localparam logic [2:0] CMD_ERROR_RESET  = 3'h3;
  localparam logic [2:0] CMD_RST_HIGH_IUS = 3'h4;
  localparam logic [2:0] CMD_RST_UNDERRUN = 3'h5;

  localparam logic [1:0] VEC_NONE       = 2'h0;
  localparam logic [1:0] VEC_TX_EMPTY   = 2'h1;
  localparam logic [1:0] VEC_RX_CHAR    = 2'h2;
  localparam logic [1:0] VEC_RX_SPECIAL = 2'h3;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [7:0] ICR_RESET   = 8'h00;
  localparam logic [7:0] MCR_RESET   = 8'h00;
  localparam int         RX_DEPTH_DEF = 3;

endpackage : sio_irq_pkg

/* File: dv/dma_model.sv */
// Behavioural DMA controller draining the receive channel.
// Assumes request and acknowledge both live on the core clock.
`timescale 1ns/10ps
module dma_model (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       en,
  input  wire logic [3:0] wait_cyc,
  input  wire logic       req,
  input  wire logic [7:0] data,
  output logic            ack,
  output logic [7:0]      last,
  output logic [7:0]      taken
);
  logic [3:0] cnt;
  // One-cycle acknowledge while request stands, optional stall first
  always @(posedge clk) begin
    ack <= 1'b0;
    if (!rst_b) begin
      {cnt, last, taken} <= 20'h00000;
    end else if (!en || !req || ack) begin
      cnt <= 4'h0;
    end else if (cnt < wait_cyc) begin
      cnt <= cnt + 4'h1;
    end else begin
      ack   <= 1'b1;
      last  <= data;
      taken <= taken + 8'h01;
    end
  end
endmodule : dma_model

/* File: dv/sio_irq_checker.sv */
// Port checks for the serial interrupt block.
// Assumes one clock domain; bound onto every sio_irq.
`timescale 1ns/10ps
module sio_irq_checker
  import sio_irq_pkg::*;
(
  input wire logic       CORE_CLK,
  input wire logic       RST_B,
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic       REG_WR,
  input wire logic       TX_LOAD,
  input wire logic       TX_FULL,
  input wire logic [7:0] TX_DATA,
  input wire logic       DMA_RX_REQ,
  input wire logic       INT_REQ_B
);
  logic       mie_q, txie_q, dma_q, wtx_q, wtx;
  logic [1:0] mode_q;
  assign wtx = REG_WR && (REG_ADDR == TX_BUFFER_REG);
  // Shadow of the control bits
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      {mie_q, txie_q, dma_q, wtx_q, mode_q} <= 6'h00;
    end else begin
      wtx_q <= wtx;
      if (REG_WR && REG_ADDR == INT_CONTROL_REG) begin
        dma_q  <= REG_WDATA[ICR_DMA_EN];
        mode_q <= REG_WDATA[ICR_MODE_LO+:2];
        txie_q <= REG_WDATA[ICR_TX_IE];
      end
      if (REG_WR && REG_ADDR == MASTER_CTRL_REG) mie_q <= REG_WDATA[MCR_MIE];
    end
  end
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  a_tx_write_fills: assert property (
    wtx && !TX_LOAD |=> TX_FULL && TX_DATA == $past(REG_WDATA))
    else $error("transmit buffer write lost");
  a_tx_full_rise: assert property ($rose(TX_FULL) |-> wtx_q)
    else $error("buffer full without a write");
  a_tx_load_empties: assert property (TX_LOAD && TX_FULL && !wtx |=> !TX_FULL)
    else $error("buffer not emptied by load");
  a_irq_needs_mie: assert property ($fell(INT_REQ_B) |-> $past(mie_q))
    else $error("request without master enable");
  a_irq_mie_off: assert property ((!mie_q) [*3] |-> INT_REQ_B)
    else $error("request held with master enable off");
  a_tx_ie_gate: assert property ((!txie_q && mode_q == RXM_OFF) [*3] |-> INT_REQ_B)
    else $error("request with sources disabled");
  a_irq_has_source: assert property (
    $fell(INT_REQ_B) |-> $past(txie_q) || $past(mode_q) != RXM_OFF)
    else $error("request from a disabled source");
  a_dma_gate: assert property ((!dma_q) [*2] |-> !DMA_RX_REQ)
    else $error("dma request while dma disabled");
endmodule : sio_irq_checker

bind sio_irq sio_irq_checker i_sio_irq_checker (.CORE_CLK(CORE_CLK), .RST_B(RST_B),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .TX_LOAD(TX_LOAD),
  .TX_FULL(TX_FULL), .TX_DATA(TX_DATA), .DMA_RX_REQ(DMA_RX_REQ), .INT_REQ_B(INT_REQ_B));

/* File: dv/tb_sio_irq.sv */
// Self-checking bench for the serial interrupt block.
// Assumes the checker is bound in and the DMA model drains receive.
`timescale 1ns/10ps
module tb_sio_irq;
  import sio_irq_pkg::*;
  logic       CORE_CLK, RST_B, REG_WR, REG_RD, RX_CHAR_VALID, TX_SYNC_MODE;
  logic       DMA_RX_REQ, DMA_RX_ACK, TX_FULL, INT_REQ_B, dma_en;
  logic [3:0] REG_ADDR, dma_wait;
  logic [7:0] REG_WDATA, REG_RDATA, RX_CHAR_DATA, TX_DATA, DMA_RX_DATA, dma_last, dma_n;
  logic [2:0] rx_err, tev;
  logic [7:0] sp_exp [3] = '{8'h10, 8'h40, 8'h80};
  int         n_mismatch, checked, i;
  sio_irq #(.RX_DEPTH(3)) i_sio_irq (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR_DATA(RX_CHAR_DATA), .RX_PARITY_ERR(rx_err[0]),
    .RX_FRAMING_ERR(rx_err[1]), .RX_END_OF_FRAME(rx_err[2]), .DMA_RX_REQ(DMA_RX_REQ),
    .DMA_RX_ACK(DMA_RX_ACK), .DMA_RX_DATA(DMA_RX_DATA), .TX_SYNC_MODE(TX_SYNC_MODE),
    .TX_LOAD(tev[0]), .TX_CRC_START(tev[1]), .TX_CRC_DONE(tev[2]), .TX_DATA(TX_DATA),
    .TX_FULL(TX_FULL), .INT_REQ_B(INT_REQ_B));
  dma_model i_dma_model (.clk(CORE_CLK), .rst_b(RST_B), .en(dma_en), .wait_cyc(dma_wait),
    .req(DMA_RX_REQ), .data(DMA_RX_DATA), .ack(DMA_RX_ACK), .last(dma_last), .taken(dma_n));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    {REG_ADDR, REG_WDATA, REG_WR} <= {a, d, 1'b1};
    @(posedge CORE_CLK);
    REG_WR <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    {REG_ADDR, REG_RD} <= {a, 1'b1};
    @(posedge CORE_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, exp);
  endtask : rd
  task automatic cmd(input logic [2:0] c);
    wr(COMMAND_REG, {2'h0, c, 3'h0});
  endtask : cmd
  task automatic push(input logic [7:0] d, input logic [2:0] e);
    @(posedge CORE_CLK);
    {RX_CHAR_VALID, RX_CHAR_DATA, rx_err} <= {1'b1, d, e};
    @(posedge CORE_CLK);
    {RX_CHAR_VALID, rx_err} <= 4'h0;
  endtask : push
  task automatic pulse(input logic [2:0] p);
    @(posedge CORE_CLK);
    tev <= p;
    @(posedge CORE_CLK);
    tev <= 3'h0;
  endtask : pulse
  task automatic irq_is(input logic v);
    repeat (3) @(posedge CORE_CLK);
    #1 chk({7'h00, INT_REQ_B}, {7'h00, v});
  endtask : irq_is
  task automatic wait_dma(input logic [7:0] n);
    for (int k = 0; k < 100 && dma_n !== n; k++) @(posedge CORE_CLK);
    chk(dma_n, n);
    if (dma_n !== n) final_report();
  endtask : wait_dma
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end
  initial begin
    {RST_B, REG_WR, REG_RD, RX_CHAR_VALID, TX_SYNC_MODE, dma_en} = 6'h00;
    {REG_ADDR, REG_WDATA, RX_CHAR_DATA, rx_err, tev, dma_wait} = 30'h0;
    {n_mismatch, checked} = 0;
    repeat (16) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    rd(PENDING_REG, 8'h00);
    rd(BASIC_STATUS_REG, 8'h04);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    $display("test reset done");
    wr(INT_CONTROL_REG, 8'h02);
    wr(TX_BUFFER_REG, 8'ha5);
    #1 chk({TX_FULL, TX_DATA[6:0]}, 8'ha5);
    rd(PENDING_REG, 8'h00);
    pulse(3'h1);
    rd(PENDING_REG, 8'h01);
    irq_is(1'b1);
    wr(MASTER_CTRL_REG, 8'h08);
    irq_is(1'b0);
    cmd(CMD_RST_TX_PEND);
    rd(PENDING_REG, 8'h00);
    wr(TX_BUFFER_REG, 8'h5a);
    pulse(3'h1);
    rd(PENDING_REG, 8'h01);
    wr(TX_BUFFER_REG, 8'h3c);
    rd(PENDING_REG, 8'h00);
    wr(INT_CONTROL_REG, 8'h00);
    pulse(3'h1);
    irq_is(1'b1);
    wr(INT_CONTROL_REG, 8'h02);
    TX_SYNC_MODE <= 1'b1;
    pulse(3'h2);
    rd(BASIC_STATUS_REG, 8'h40);
    pulse(3'h4);
    rd(BASIC_STATUS_REG, 8'h44);
    rd(PENDING_REG, 8'h01);
    cmd(CMD_RST_UNDERRUN);
    cmd(CMD_RST_TX_PEND);
    TX_SYNC_MODE <= 1'b0;
    pulse(3'h4);
    rd(PENDING_REG, 8'h00);
    $display("test transmit done");
    push(8'h11, 3'h0);
    wr(INT_CONTROL_REG, 8'h08);
    rd(PENDING_REG, 8'h02);
    rd(VECTOR_REG, {6'h00, VEC_RX_CHAR});
    rd(RX_DATA_REG, 8'h11);
    rd(PENDING_REG, 8'h00);
    push(8'h22, 3'h0);
    rd(PENDING_REG, 8'h00);
    rd(RX_DATA_REG, 8'h22);
    cmd(CMD_RST_HIGH_IUS);
    cmd(CMD_EN_NEXT_CHAR);
    push(8'h33, 3'h0);
    rd(PENDING_REG, 8'h02);
    rd(RX_DATA_REG, 8'h33);
    wr(INT_CONTROL_REG, 8'h0c);
    for (i = 0; i < 3; i++) begin
      push(8'h40 + i[7:0], 3'h1 << i);
      push(8'h50, 3'h0);
      rd(RX_DATA_REG, 8'h40 + i[7:0]);
      rd(PENDING_REG, 8'h02);
      rd(SPECIAL_STAT_REG, sp_exp[i]);
      rd(VECTOR_REG, {6'h00, VEC_RX_SPECIAL});
      rd(BASIC_STATUS_REG, 8'h04);
      rd(RX_DATA_REG, 8'h40 + i[7:0]);
      cmd(CMD_ERROR_RESET);
      cmd(CMD_RST_HIGH_IUS);
      rd(RX_DATA_REG, 8'h50);
    end
    cmd(CMD_EN_NEXT_CHAR);
    push(8'h61, 3'h0);
    rd(PENDING_REG, 8'h02);
    rd(RX_DATA_REG, 8'h61);
    wr(INT_CONTROL_REG, 8'h8c);
    dma_en <= 1'b1;
    push(8'h62, 3'h0);
    wait_dma(8'h01);
    chk(dma_last, 8'h62);
    $display("test first character done");
    wr(INT_CONTROL_REG, 8'h98);
    push(8'h66, 3'h0);
    wait_dma(8'h02);
    rd(PENDING_REG, 8'h00);
    dma_wait <= 4'h3;
    push(8'h77, 3'h4);
    push(8'h88, 3'h0);
    wait_dma(8'h03);
    repeat (20) @(posedge CORE_CLK);
    chk(dma_n, 8'h03);
    rd(PENDING_REG, 8'h02);
    cmd(CMD_ERROR_RESET);
    wait_dma(8'h04);
    chk(dma_last, 8'h88);
    dma_en <= 1'b0;
    $display("test special only done");
    push(8'h91, 3'h0);
    wr(INT_CONTROL_REG, 8'h10);
    push(8'h92, 3'h2);
    rd(PENDING_REG, 8'h02);
    rd(RX_DATA_REG, 8'h91);
    rd(SPECIAL_STAT_REG, 8'h40);
    rd(PENDING_REG, 8'h02);
    rd(BASIC_STATUS_REG, 8'h05);
    rd(RX_DATA_REG, 8'h92);
    cmd(CMD_ERROR_RESET);
    rd(PENDING_REG, 8'h00);
    $display("test all characters done");
    wr(MASTER_CTRL_REG, 8'h0c);
    wr(INT_CONTROL_REG, 8'h18);
    for (i = 0; i < 4; i++) push(8'ha0 + i[7:0], 3'h0);
    rd(RX_DATA_REG, 8'ha0);
    rd(RX_DATA_REG, 8'ha1);
    rd(RX_DATA_REG, 8'ha3);
    push(8'hb0, 3'h0);
    rd(BASIC_STATUS_REG, 8'h05);
    rd(RX_DATA_REG, 8'hb0);
    rd(PENDING_REG, 8'h02);
    cmd(CMD_ERROR_RESET);
    rd(PENDING_REG, 8'h00);
    $display("test status fifo done");
    final_report();
  end
endmodule : tb_sio_irq
